/* core/vbc_bus_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module vbc_bus_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Decodes and onboard inputs
	input wire logic board_slave_decode_n,
	input wire logic vme_target_decode_n,
	input wire logic onboard_target_decode,
	input wire logic local_bus_request_n,
	input wire logic release_request,
	input wire logic data_strobe_in,
	input wire logic read_write_n,
	// Arbitration pins
	input wire logic grant_in_n,
	output logic grant_out_n,
	output logic bus_request_n_o,
	output logic bus_request_n_oe,
	input wire logic bus_busy_n_i,
	output logic bus_busy_n_o,
	output logic bus_busy_n_oe,
	// Address strobes
	input wire logic bus_addr_strobe_n_i,
	output logic bus_addr_strobe_n_o,
	output logic bus_addr_strobe_n_oe,
	input wire logic local_master_addr_strobe_n_i,
	output logic local_master_addr_strobe_n_o,
	output logic local_master_addr_strobe_n_oe,
	// Local grant
	input wire logic local_bus_grant_pin_n_i,
	output logic local_bus_grant_pin_n_o,
	output logic local_bus_grant_pin_n_oe,
	// Responses
	input wire logic bus_ack_n_i,
	output logic bus_ack_n_o,
	output logic bus_ack_n_oe,
	input wire logic bus_error_n_i,
	output logic bus_error_n_o,
	output logic bus_error_n_oe,
	input wire logic local_ack_n_i,
	output logic local_ack_n_o,
	output logic local_ack_n_oe,
	input wire logic local_bus_error_n_i,
	output logic local_bus_error_n_o,
	output logic local_bus_error_n_oe,
	// Transceiver and select controls
	output logic local_master_enable_n,
	output logic vme_addr_enable_n,
	output logic onboard_slave_select_n,
	output logic strobe_drive_enable_n,
	output logic data_transceiver_direction,
	output logic data_transceiver_enable_n
);
	import vbc_pkg::*;

	vbc_arb_if arb ();

	vbc_cyc_state_t st_q, st_d;
	logic men_q, men_d, aen_q, aen_d, sel_q, sel_d;
	logic as_oe_q, as_oe_d, mas_oe_q, mas_oe_d, mas_o_q, mas_o_d;
	logic sen_q, sen_d, dir_q, dir_d, den_q, den_d;
	logic lack_q, lack_d, lberr_q, lberr_d, vack_q, vack_d, vberr_q, vberr_d;
	logic lbg_q, lbg_d, want_q, want_d;
	logic strap_q, strap_d, strap_done_q, strap_done_d;
	logic low_q;
	logic mas_seen, as_seen;

	// ==========================================
	// Bus arbitration
	vbc_arbiter u_arb (
		.clk(clk),
		.reset(reset),
		.arb(arb.arb_mp),
		.grant_in_n(grant_in_n),
		.bus_busy_n_i(bus_busy_n_i),
		.local_bus_request_n(local_bus_request_n),
		.release_request(release_request),
		.bus_request_n_oe(bus_request_n_oe),
		.bus_busy_n_oe(bus_busy_n_oe),
		.grant_out_n(grant_out_n)
	);

	assign arb.want_bus = want_q;

	// ==========================================
	// Strap capture, once after reset release
	always_comb begin
		strap_d = strap_q;
		strap_done_d = 1'b1;
		if (!strap_done_q) begin
			strap_d = local_bus_grant_pin_n_i;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_q <= NEGATED;
			strap_done_q <= NEGATED;
			low_q <= PULL_LOW;
		end else begin
			strap_q <= strap_d;
			strap_done_q <= strap_done_d;
			low_q <= PULL_LOW;
		end
	end

	// ==========================================
	// Cycle control
	// Own drive of a strobe must not look like a new cycle
	assign mas_seen = !mas_oe_q && !local_master_addr_strobe_n_i;
	assign as_seen = !as_oe_q && !bus_addr_strobe_n_i;
	assign arb.as_decision = (st_q == VBC_M_DEC) || (st_q == VBC_M_XFER);

	always_comb begin
		st_d = st_q;
		men_d = men_q;
		aen_d = aen_q;
		sel_d = sel_q;
		as_oe_d = as_oe_q;
		sen_d = NEGATED_N;
		dir_d = dir_q;
		den_d = NEGATED_N;
		lack_d = NEGATED;
		lberr_d = NEGATED;
		vack_d = NEGATED;
		vberr_d = NEGATED;
		want_d = NEGATED;
		unique case (st_q)
			VBC_IDLE: begin
				if (mas_seen) begin
					st_d = VBC_M_DEC;
				end else if (as_seen) begin
					st_d = VBC_S_DEC;
				end
			end
			VBC_M_DEC: begin
				// Decodes sampled one clock after the strobe was seen
				if (local_master_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
				end else if (onboard_target_decode) begin
					st_d = VBC_L_SETUP;
					men_d = 1'b0;
					aen_d = NEGATED_N;
				end else if (!vme_target_decode_n) begin
					want_d = 1'b1;
					if (arb.have_bus && !as_seen) begin
						st_d = VBC_M_XFER;
						men_d = 1'b0;
						aen_d = 1'b0;
						as_oe_d = 1'b1;
					end
				end else begin
					st_d = VBC_WAIT_MAS;
				end
			end
			VBC_M_XFER: begin
				// Strobe stays low across chained data strobes
				if (local_master_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
					as_oe_d = NEGATED;
					men_d = NEGATED_N;
					aen_d = NEGATED_N;
				end else begin
					want_d = 1'b1;
					dir_d = !read_write_n;
					sen_d = !data_strobe_in;
					den_d = !data_strobe_in;
					// Responses relayed only while the strobe is up
					lack_d = data_strobe_in && !bus_ack_n_i;
					lberr_d = data_strobe_in && !bus_error_n_i;
				end
			end
			VBC_L_SETUP: begin
				st_d = VBC_L_XFER;
				sel_d = 1'b0;
			end
			VBC_L_XFER: begin
				if (local_master_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
					sel_d = NEGATED_N;
					men_d = NEGATED_N;
				end
			end
			VBC_S_DEC: begin
				if (bus_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
				end else if (!board_slave_decode_n) begin
					st_d = VBC_S_SETUP;
					men_d = NEGATED_N;
					aen_d = 1'b0;
				end else begin
					st_d = VBC_WAIT_AS;
				end
			end
			VBC_S_SETUP: begin
				// One clock of address setup before the select
				st_d = VBC_S_XFER;
				sel_d = 1'b0;
			end
			VBC_S_XFER: begin
				if (bus_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
					sel_d = NEGATED_N;
					aen_d = NEGATED_N;
				end else begin
					dir_d = read_write_n;
					den_d = !data_strobe_in;
					vack_d = data_strobe_in && !local_ack_n_i;
					vberr_d = data_strobe_in && !local_bus_error_n_i;
				end
			end
			VBC_WAIT_MAS: begin
				// Ignored local-slave cycle must not block a bus slave cycle
				if (local_master_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
				end else if (as_seen) begin
					st_d = VBC_S_DEC;
				end
			end
			VBC_WAIT_AS: begin
				if (bus_addr_strobe_n_i) begin
					st_d = VBC_IDLE;
				end
			end
			default: begin
				st_d = VBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= VBC_IDLE;
			men_q <= NEGATED_N;
			aen_q <= NEGATED_N;
			sel_q <= NEGATED_N;
			as_oe_q <= NEGATED;
			sen_q <= NEGATED_N;
			dir_q <= NEGATED;
			den_q <= NEGATED_N;
			lack_q <= NEGATED;
			lberr_q <= NEGATED;
			vack_q <= NEGATED;
			vberr_q <= NEGATED;
			want_q <= NEGATED;
		end else begin
			st_q <= st_d;
			men_q <= men_d;
			aen_q <= aen_d;
			sel_q <= sel_d;
			as_oe_q <= as_oe_d;
			sen_q <= sen_d;
			dir_q <= dir_d;
			den_q <= den_d;
			lack_q <= lack_d;
			lberr_q <= lberr_d;
			vack_q <= vack_d;
			vberr_q <= vberr_d;
			want_q <= want_d;
		end
	end

	// ==========================================
	// Strobe mirror and local grant
	always_comb begin
		// Mirror lags the bus strobe by one clock
		mas_oe_d = strap_done_q && strap_q && !arb.have_bus;
		mas_o_d = bus_addr_strobe_n_i;
		lbg_d = !local_bus_request_n && arb.have_bus;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mas_oe_q <= NEGATED;
			mas_o_q <= NEGATED_N;
			lbg_q <= NEGATED;
		end else begin
			mas_oe_q <= mas_oe_d;
			mas_o_q <= mas_o_d;
			lbg_q <= lbg_d;
		end
	end

	// ==========================================
	// Pins
	assign bus_request_n_o = low_q;
	assign bus_busy_n_o = low_q;
	assign bus_addr_strobe_n_o = low_q;
	assign bus_addr_strobe_n_oe = as_oe_q;
	assign local_master_addr_strobe_n_o = mas_o_q;
	assign local_master_addr_strobe_n_oe = mas_oe_q;
	assign local_bus_grant_pin_n_o = low_q;
	assign local_bus_grant_pin_n_oe = lbg_q;
	assign bus_ack_n_o = low_q;
	assign bus_ack_n_oe = vack_q;
	assign bus_error_n_o = low_q;
	assign bus_error_n_oe = vberr_q;
	assign local_ack_n_o = low_q;
	assign local_ack_n_oe = lack_q;
	assign local_bus_error_n_o = low_q;
	assign local_bus_error_n_oe = lberr_q;
	assign local_master_enable_n = men_q;
	assign vme_addr_enable_n = aen_q;
	assign onboard_slave_select_n = sel_q;
	assign strobe_drive_enable_n = sen_q;
	assign data_transceiver_direction = dir_q;
	assign data_transceiver_enable_n = den_q;
endmodule // vbc_bus_ctrl
`default_nettype wire

/* core/vbc_pkg.sv */
package vbc_pkg;
	// ==========================================
	// Reset values
	localparam logic NEGATED_N = 1'b1;
	localparam logic NEGATED = 1'b0;
	localparam logic PULL_LOW = 1'b0;

	// ==========================================
	// Cycle control states
	typedef enum logic [3:0] {
		VBC_IDLE = 4'h0,
		VBC_M_DEC = 4'h1,
		VBC_M_XFER = 4'h2,
		VBC_L_SETUP = 4'h3,
		VBC_L_XFER = 4'h4,
		VBC_S_DEC = 4'h5,
		VBC_S_SETUP = 4'h6,
		VBC_S_XFER = 4'h7,
		VBC_WAIT_MAS = 4'h8,
		VBC_WAIT_AS = 4'h9
	} vbc_cyc_state_t;

	// ==========================================
	// Arbitration states
	typedef enum logic [1:0] {
		VBC_ARB_IDLE = 2'h0,
		VBC_ARB_REQ = 2'h1,
		VBC_ARB_OWN = 2'h2,
		VBC_ARB_PASS = 2'h3
	} vbc_arb_state_t;
endpackage

/* core/vbc_arb_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface vbc_arb_if;
	logic want_bus;
	logic as_decision;
	logic have_bus;

	modport cyc_mp (
		output want_bus,
		output as_decision,
		input have_bus
	);
	modport arb_mp (
		input want_bus,
		input as_decision,
		output have_bus
	);
endinterface
`default_nettype wire

/* core/vbc_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module vbc_arbiter (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link to cycle control
	vbc_arb_if.arb_mp arb,
	// Bus arbitration pins
	input wire logic grant_in_n,
	input wire logic bus_busy_n_i,
	input wire logic local_bus_request_n,
	input wire logic release_request,
	output logic bus_request_n_oe,
	output logic bus_busy_n_oe,
	output logic grant_out_n
);
	import vbc_pkg::*;

	vbc_arb_state_t st_q, st_d;
	logic req_q, req_d, bsy_q, bsy_d, gout_q, gout_d, rel_pend_q, rel_pend_d;
	logic rel_cond;

	// ==========================================
	// Next state
	always_comb begin
		st_d = st_q;
		req_d = req_q;
		bsy_d = bsy_q;
		gout_d = NEGATED_N;
		rel_pend_d = 1'b0;
		rel_cond = grant_in_n & release_request & local_bus_request_n;
		unique case (st_q)
			VBC_ARB_IDLE: begin
				if (!grant_in_n) begin
					st_d = VBC_ARB_PASS;
					gout_d = 1'b0;
				end else if (arb.want_bus && bus_busy_n_i) begin
					st_d = VBC_ARB_REQ;
					req_d = 1'b1;
				end
			end
			VBC_ARB_REQ: begin
				// Grant arrives while we ask: take the bus, drop the request
				if (!grant_in_n && bus_busy_n_i) begin
					st_d = VBC_ARB_OWN;
					req_d = 1'b0;
					bsy_d = 1'b1;
				end else if (!arb.want_bus) begin
					st_d = VBC_ARB_IDLE;
					req_d = 1'b0;
				end
			end
			VBC_ARB_OWN: begin
				// Strobe decision pending: hold busy one more clock
				if (rel_cond && (arb.as_decision || rel_pend_q) && !rel_pend_q) begin
					rel_pend_d = 1'b1;
				end else if (rel_cond) begin
					st_d = VBC_ARB_IDLE;
					bsy_d = 1'b0;
				end
			end
			VBC_ARB_PASS: begin
				gout_d = grant_in_n;
				if (grant_in_n) begin
					st_d = VBC_ARB_IDLE;
				end
			end
		endcase
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= VBC_ARB_IDLE;
			req_q <= NEGATED;
			bsy_q <= NEGATED;
			gout_q <= NEGATED_N;
			rel_pend_q <= NEGATED;
		end else begin
			st_q <= st_d;
			req_q <= req_d;
			bsy_q <= bsy_d;
			gout_q <= gout_d;
			rel_pend_q <= rel_pend_d;
		end
	end

	assign bus_request_n_oe = req_q;
	assign bus_busy_n_oe = bsy_q;
	assign grant_out_n = gout_q;
	assign arb.have_bus = bsy_q;
endmodule // vbc_arbiter
`default_nettype wire

/* bench/vbc_bus_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module vbc_bus_ctrl_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Arbitration
	input wire logic grant_in_n,
	input wire logic bus_busy_n_i,
	input wire logic local_bus_request_n,
	input wire logic release_request,
	input wire logic bus_request_n_oe,
	input wire logic bus_busy_n_oe,
	input wire logic grant_out_n,
	input wire logic local_bus_grant_pin_n_oe,
	// Cycle control
	input wire logic local_master_addr_strobe_n_i,
	input wire logic bus_addr_strobe_n_i,
	input wire logic board_slave_decode_n,
	input wire logic vme_target_decode_n,
	input wire logic onboard_target_decode,
	input wire logic data_strobe_in,
	input wire logic read_write_n,
	input wire logic local_master_enable_n,
	input wire logic onboard_slave_select_n,
	input wire logic strobe_drive_enable_n,
	input wire logic data_transceiver_direction,
	input wire logic data_transceiver_enable_n
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (reset);
	bus_req_a: assert property ($rose(bus_request_n_oe) |-> $past(bus_busy_n_i))
		else $error("request while bus busy");
	busy_take_a: assert property ($rose(bus_busy_n_oe) |-> $past(!grant_in_n) && !bus_request_n_oe)
		else $error("busy taken without grant");
	busy_rel_a: assert property (bus_busy_n_oe && grant_in_n && release_request && local_bus_request_n
		|-> ##[1:2] !bus_busy_n_oe)
		else $error("busy not released");
	grant_out_a: assert property (!grant_out_n |-> $past(!grant_in_n) && !bus_busy_n_oe)
		else $error("grant passed wrongly");
	local_grant_a: assert property (local_bus_grant_pin_n_oe |->
		$past(!local_bus_request_n && bus_busy_n_oe))
		else $error("local grant unrequested");
	sel_src_a: assert property ($fell(onboard_slave_select_n) |->
		$past(!local_master_addr_strobe_n_i && onboard_target_decode
		|| !bus_addr_strobe_n_i && !board_slave_decode_n))
		else $error("select without cause");
	local_ign_a: assert property (!local_master_enable_n |->
		$past(!vme_target_decode_n || onboard_target_decode))
		else $error("local slave cycle taken");
	dir_a: assert property (!data_transceiver_enable_n && $stable(read_write_n) |->
		data_transceiver_direction == (local_master_enable_n ? read_write_n : !read_write_n))
		else $error("wrong data direction");
	strobe_en_a: assert property (!strobe_drive_enable_n |-> $past(data_strobe_in))
		else $error("strobe enable without strobe");
endmodule // vbc_bus_ctrl_asserts
bind vbc_bus_ctrl vbc_bus_ctrl_asserts u_chk (.*);
`default_nettype wire

/* bench/vbc_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vbc_far_model (
	// Clock and reply delay
	input wire logic clk,
	input wire logic [3:0] lat,
	// Strobes seen
	input wire logic sel_n,
	input wire logic ds,
	input wire logic sen_n,
	// Replies, released lines float high
	output logic slv_ack,
	output logic vme_ack
);
	int n;
	always_ff @(posedge clk)
		n <= (ds && !(sel_n && sen_n)) ? n + 1 : 0;
	// Reply only once selected and strobed
	assign slv_ack = !sel_n && ds && n > lat;
	assign vme_ack = !sen_n && ds && n > lat;
endmodule // vbc_far_model
`default_nettype wire

/* bench/vbc_bus_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module vbc_bus_ctrl_tb;
	// ====
	// Pins
	logic clk, reset, board_slave_decode_n, vme_target_decode_n, onboard_target_decode;
	logic local_bus_request_n, release_request, data_strobe_in, read_write_n, grant_in_n;
	logic grant_out_n, bus_request_n_o, bus_request_n_oe, bus_busy_n_i, bus_busy_n_o, bus_busy_n_oe;
	logic bus_addr_strobe_n_i, bus_addr_strobe_n_o, bus_addr_strobe_n_oe;
	logic local_master_addr_strobe_n_i, local_master_addr_strobe_n_o, local_master_addr_strobe_n_oe;
	logic local_bus_grant_pin_n_i, local_bus_grant_pin_n_o, local_bus_grant_pin_n_oe;
	logic bus_ack_n_i, bus_ack_n_o, bus_ack_n_oe, bus_error_n_i, bus_error_n_o, bus_error_n_oe;
	logic local_ack_n_i, local_ack_n_o, local_ack_n_oe;
	logic local_bus_error_n_i, local_bus_error_n_o, local_bus_error_n_oe;
	logic local_master_enable_n, vme_addr_enable_n, onboard_slave_select_n, strobe_drive_enable_n;
	logic data_transceiver_direction, data_transceiver_enable_n;
	logic mas_n, oth_as, oth_busy, strap, slv_ack, vme_ack, slv_err, vme_err;
	logic [3:0] lat;
	int n_fail, cmp_count, i;
	// ====
	// Open-collector wires, pulled high
	assign bus_busy_n_i = !(bus_busy_n_oe || oth_busy);
	assign bus_addr_strobe_n_i = !(bus_addr_strobe_n_oe || oth_as);
	assign local_master_addr_strobe_n_i = mas_n && !(local_master_addr_strobe_n_oe
		&& !local_master_addr_strobe_n_o);
	assign local_bus_grant_pin_n_i = !(local_bus_grant_pin_n_oe || strap);
	assign bus_ack_n_i = !(bus_ack_n_oe || vme_ack);
	assign bus_error_n_i = !(bus_error_n_oe || vme_err);
	assign local_ack_n_i = !(local_ack_n_oe || slv_ack);
	assign local_bus_error_n_i = !(local_bus_error_n_oe || slv_err);
	vbc_bus_ctrl u_dut (.*);
	vbc_far_model u_far (.clk, .lat, .sel_n(onboard_slave_select_n), .ds(data_strobe_in),
		.sen_n(strobe_drive_enable_n), .slv_ack, .vme_ack);
	always #25 clk = !clk;
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Strap held through the first edge after release
	task rst(input logic s);
		strap = s;
		reset = 1;
		cyc(2);
		chk({local_master_enable_n, vme_addr_enable_n, onboard_slave_select_n, strobe_drive_enable_n,
			data_transceiver_enable_n, grant_out_n, bus_busy_n_oe, bus_request_n_oe}, 8'hfc);
		chk({bus_request_n_o, bus_busy_n_o, bus_addr_strobe_n_o, local_bus_grant_pin_n_o, bus_ack_n_o,
			bus_error_n_o, local_ack_n_o, local_bus_error_n_o}, 8'h00);
		reset = 0;
		cyc(1);
		strap = 0;
	endtask
	// Far longer than the whole sequence
	initial begin
		#200us;
		n_fail++;
		end_sim();
	end
	initial begin
		clk = 0;
		{board_slave_decode_n, vme_target_decode_n, mas_n, local_bus_request_n, grant_in_n} = 5'h1f;
		{onboard_target_decode, release_request, data_strobe_in, oth_as, oth_busy} = 5'h00;
		{slv_err, vme_err} = 2'h0;
		read_write_n = 1;
		lat = 4'h0;
		rst(1);
		onboard_target_decode = 1;
		mas_n = 0;
		for (i = 0; i < 8 && onboard_slave_select_n; i++) cyc(1);
		chk({local_master_enable_n, onboard_slave_select_n}, 8'h0);
		mas_n = 1;
		cyc(2);
		chk(onboard_slave_select_n, 8'h1);
		onboard_target_decode = 0;
		cyc(2);
		// Local-slave master cycle beside a slave read from another master
		mas_n = 0;
		oth_as = 1;
		board_slave_decode_n = 0;
		for (i = 0; i < 8 && onboard_slave_select_n; i++) cyc(1);
		chk({local_master_enable_n, vme_addr_enable_n, onboard_slave_select_n, bus_request_n_oe,
			local_master_addr_strobe_n_oe}, 8'h10);
		lat = 4'h2;
		data_strobe_in = 1;
		cyc(6);
		chk({data_transceiver_enable_n, data_transceiver_direction, bus_ack_n_oe}, 8'h3);
		// Slave error relayed to the bus while the strobe stands
		slv_err = 1;
		cyc(2);
		chk(bus_error_n_oe, 8'h1);
		slv_err = 0;
		data_strobe_in = 0;
		{oth_as, mas_n, board_slave_decode_n} = 3'h3;
		cyc(3);
		chk(onboard_slave_select_n, 8'h1);
		// Bus write, busy held by another master first
		oth_busy = 1;
		vme_target_decode_n = 0;
		onboard_target_decode = 0;
		read_write_n = 0;
		mas_n = 0;
		cyc(6);
		chk(bus_request_n_oe, 8'h0);
		oth_busy = 0;
		for (i = 0; i < 8 && !bus_request_n_oe; i++) cyc(1);
		chk(bus_request_n_oe, 8'h1);
		grant_in_n = 0;
		for (i = 0; i < 8 && !bus_busy_n_oe; i++) cyc(1);
		chk({bus_busy_n_oe, grant_out_n}, 8'h3);
		grant_in_n = 1;
		local_bus_request_n = 0;
		cyc(2);
		for (i = 0; i < 8 && !bus_addr_strobe_n_oe; i++) cyc(1);
		chk({bus_addr_strobe_n_oe, local_master_enable_n, vme_addr_enable_n,
			local_bus_grant_pin_n_oe}, 8'h9);
		local_bus_request_n = 1;
		lat = 4'h0;
		// Two data strobes under one master strobe
		repeat (2) begin
			data_strobe_in = 1;
			cyc(4);
			chk({strobe_drive_enable_n, data_transceiver_enable_n, data_transceiver_direction,
				local_ack_n_oe}, 8'h3);
			data_strobe_in = 0;
			cyc(2);
			chk(local_ack_n_oe, 8'h0);
		end
		// Bus error relayed back to the master
		vme_err = 1;
		data_strobe_in = 1;
		cyc(2);
		chk(local_bus_error_n_oe, 8'h1);
		{vme_err, data_strobe_in} = 2'h0;
		cyc(2);
		mas_n = 1;
		cyc(3);
		chk({bus_addr_strobe_n_oe, local_master_enable_n, bus_busy_n_oe}, 8'h3);
		release_request = 1;
		cyc(3);
		chk(bus_busy_n_oe, 8'h0);
		{release_request, vme_target_decode_n, read_write_n} = 3'h3;
		grant_in_n = 0;
		cyc(2);
		chk(grant_out_n, 8'h0);
		grant_in_n = 1;
		cyc(2);
		chk(grant_out_n, 8'h1);
		// Strap high: bus strobe copied onto master strobe
		rst(0);
		oth_as = 1;
		cyc(3);
		chk({local_master_addr_strobe_n_oe, local_master_addr_strobe_n_i}, 8'h2);
		oth_as = 0;
		cyc(3);
		chk(local_master_addr_strobe_n_i, 8'h1);
		end_sim();
	end
endmodule // vbc_bus_ctrl_tb
`default_nettype wire
